// ==== tmr_pkg.sv ====
// ==========================================
// timer package
package tmr_pkg;
    localparam int TMR_ADDR_W = 5; // register address width
    localparam int TMR_DATA_W = 8; // register data width
    localparam int TMR_CNT_W = 16; // counter width
    localparam int TMR_NCH = 4; // channel count
    localparam int TMR_PSC_W = 7; // prescaler stages
    // ==========================================
    // register offsets
    localparam logic [4:0] OFS_STATUS = 5'h00;
    localparam logic [4:0] OFS_CNT_HI = 5'h01;
    localparam logic [4:0] OFS_CNT_LO = 5'h02;
    localparam logic [4:0] OFS_MOD_HI = 5'h03;
    localparam logic [4:0] OFS_MOD_LO = 5'h04;
    localparam logic [4:0] OFS_CH_BASE = 5'h05; // channel c control
    localparam logic [4:0] OFS_CH_STEP = 5'h03; // ctrl, cmp hi, cmp lo
    // ==========================================
    // status/control bits
    localparam int B_WRAP_FLAG = 7;
    localparam int B_WRAP_IE = 6;
    localparam int B_HALT = 5;
    localparam int B_CLEAR = 4;
    // channel control bits
    localparam int B_CH_FLAG = 7;
    localparam int B_CH_IE = 6;
    localparam int B_BUF = 5;
    localparam int B_SINGLE = 4;
    localparam int B_ELS = 2; // two bits, 3:2
    localparam int B_TOGGLE = 1;
    localparam int B_FULL = 0;
    // ==========================================
    // codes and reset values
    localparam logic [2:0] DIV_EXT = 3'h7;
    localparam logic [1:0] ELS_PORT = 2'h0;
    localparam logic [1:0] ELS_TOGGLE = 2'h1;
    localparam logic [1:0] ELS_CLEAR = 2'h2;
    localparam logic [1:0] ELS_SET = 2'h3;
    localparam logic RST_HALT = 1'b1;
    localparam logic [2:0] RST_DIV = 3'h0;
    localparam logic [15:0] RST_MOD = 16'hFFFF;
    localparam logic [15:0] RST_CNT = 16'h0000;
    localparam logic [7:0] RST_CTL = 8'h00;
    localparam logic RST_OUT = 1'b1;
endpackage : tmr_pkg

// ==== tmr_four_channel.sv ====
// ==========================================
// four channel timer
//
// The strobed register port and the register offsets were chosen for this implementation.
module tmr_four_channel (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [tmr_pkg::TMR_ADDR_W-1:0] i_addr,
    input wire logic [tmr_pkg::TMR_DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [tmr_pkg::TMR_DATA_W-1:0] o_rdata,
    input wire logic i_wait_mode,
    input wire logic i_break_active,
    input wire logic i_break_flag_clear_enable,
    input wire logic i_ext_clk_pin,
    input wire logic i_port_d6_dir,
    input wire logic i_port_d6_out,
    output logic o_ext_clk_out,
    output logic o_ext_clk_oe,
    input wire logic [tmr_pkg::TMR_NCH-1:0] i_chan_pin,
    input wire logic [tmr_pkg::TMR_NCH-1:0] i_port_chan_dir,
    input wire logic [tmr_pkg::TMR_NCH-1:0] i_port_chan_out,
    output logic [tmr_pkg::TMR_NCH-1:0] o_chan_out,
    output logic [tmr_pkg::TMR_NCH-1:0] o_chan_oe,
    output logic o_irq
);
    import tmr_pkg::*;

    // ==========================================
    // flag step: read arms, write zero clears, set wins
    function automatic logic [1:0] flag_step(input logic flag, input logic arm,
        input logic rd_hit, input logic wr_hit, input logic wbit,
        input logic set, input logic allow);
        logic f;
        logic a;
        f = flag;
        a = arm;
        if (rd_hit && flag && allow) begin
            a = 1'b1;
        end
        if (wr_hit && !wbit && arm && allow) begin
            f = 1'b0;
            a = 1'b0;
        end
        if (set) begin // new event voids a pending clear
            f = 1'b1;
            a = 1'b0;
        end
        return {f, a};
    endfunction : flag_step

    // ==========================================
    // bus qualifiers
    logic wr; // write accepted
    logic rd; // read accepted
    logic allow; // flag clearing permitted
    assign wr = i_wr & ~i_wait_mode;
    assign rd = i_rd & ~i_wait_mode;
    assign allow = ~i_break_active | i_break_flag_clear_enable;

    // ==========================================
    // pin synchronisers, first stage feeds only the second
    logic [1:0] ext_sync_ff;
    logic ext_prev_ff;
    logic [TMR_NCH-1:0] ch_s1_ff;
    logic [TMR_NCH-1:0] ch_s2_ff;
    logic [TMR_NCH-1:0] ch_prev_ff;
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ext_sync_ff <= 2'h0;
            ext_prev_ff <= 1'b0;
            ch_s1_ff <= '0;
            ch_s2_ff <= '0;
            ch_prev_ff <= '0;
        end else begin
            ext_sync_ff <= {ext_sync_ff[0], i_ext_clk_pin};
            ext_prev_ff <= ext_sync_ff[1];
            ch_s1_ff <= i_chan_pin;
            ch_s2_ff <= ch_s1_ff;
            ch_prev_ff <= ch_s2_ff;
        end
    end

    // ==========================================
    // status/control and counter state
    logic wrap_flag_ff, nxt_wrap_flag;
    logic wrap_arm_ff, nxt_wrap_arm;
    logic wrap_ie_ff, nxt_wrap_ie;
    logic halt_ff, nxt_halt;
    logic [2:0] div_ff, nxt_div;
    logic [15:0] mod_ff, nxt_mod;
    logic [15:0] cnt_ff, nxt_cnt;
    logic [TMR_PSC_W-1:0] psc_ff, nxt_psc;
    logic [TMR_PSC_W-1:0] mask; // prescaler tap mask
    logic tick; // selected count clock tick
    logic adv; // counter steps this cycle
    logic wrap_ev; // modulo match rollover
    logic clr_req; // write of the clear bit
    logic wr_st; // write to status
    logic [1:0] wstep;

    // counter, prescaler, status next values
    always_comb begin
        wr_st = wr && (i_addr == OFS_STATUS);
        clr_req = wr_st && i_wdata[B_CLEAR];
        mask = TMR_PSC_W'((8'h01 << div_ff) - 8'h01);
        if (div_ff == DIV_EXT) begin
            tick = ext_sync_ff[1] & ~ext_prev_ff;
        end else begin
            tick = ((psc_ff & mask) == mask);
        end
        adv = tick && !halt_ff && !i_break_active;
        wrap_ev = adv && (cnt_ff == mod_ff);
        nxt_psc = clr_req ? '0 : psc_ff + 1'b1;
        nxt_cnt = cnt_ff;
        if (clr_req) begin
            nxt_cnt = RST_CNT;
        end else if (adv) begin
            nxt_cnt = wrap_ev ? RST_CNT : cnt_ff + 16'h0001;
        end
        nxt_wrap_ie = wrap_ie_ff;
        nxt_halt = halt_ff;
        nxt_div = div_ff;
        if (wr_st) begin // clear bit is write-only
            nxt_wrap_ie = i_wdata[B_WRAP_IE];
            nxt_halt = i_wdata[B_HALT];
            nxt_div = i_wdata[2:0];
        end
        nxt_mod = mod_ff;
        if (wr && i_addr == OFS_MOD_HI) begin
            nxt_mod[15:8] = i_wdata;
        end
        if (wr && i_addr == OFS_MOD_LO) begin
            nxt_mod[7:0] = i_wdata;
        end
        wstep = flag_step(wrap_flag_ff, wrap_arm_ff, rd && (i_addr == OFS_STATUS),
            wr_st, i_wdata[B_WRAP_FLAG], wrap_ev, allow);
        nxt_wrap_flag = wstep[1];
        nxt_wrap_arm = wstep[0];
    end

    // register status and counter
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wrap_flag_ff <= 1'b0;
            wrap_arm_ff <= 1'b0;
            wrap_ie_ff <= 1'b0;
            halt_ff <= RST_HALT;
            div_ff <= RST_DIV;
            mod_ff <= RST_MOD;
            cnt_ff <= RST_CNT;
            psc_ff <= '0;
        end else begin
            wrap_flag_ff <= nxt_wrap_flag;
            wrap_arm_ff <= nxt_wrap_arm;
            wrap_ie_ff <= nxt_wrap_ie;
            halt_ff <= nxt_halt;
            div_ff <= nxt_div;
            mod_ff <= nxt_mod;
            cnt_ff <= nxt_cnt;
            psc_ff <= nxt_psc;
        end
    end

    // external clock pin: port pin unless selected
    assign o_ext_clk_oe = (div_ff == DIV_EXT) ? 1'b0 : i_port_d6_dir;
    assign o_ext_clk_out = i_port_d6_out;

    // ==========================================
    // channel state
    logic [7:0] ctl_ff [TMR_NCH];
    logic [15:0] cmp_ff [TMR_NCH];
    logic [TMR_NCH-1:0] chf_ff;
    logic [TMR_NCH-1:0] charm_ff;
    logic [TMR_NCH-1:0] out_ff;
    logic [TMR_NCH-1:0] dis; // odd channel swallowed by its pair
    logic [TMR_NCH-1:0] ch_irq;
    logic [1:0] pair_on; // buffered pair active
    logic [1:0] sel_ff; // pair uses odd channel compare
    logic [1:0] last_ff; // compare set written last

    genvar c;
    generate
        for (c = 0; c < TMR_NCH; c++) begin : g_ch
            localparam logic [4:0] A_CTL = 5'(OFS_CH_BASE + c * OFS_CH_STEP);
            localparam logic [4:0] A_HI = 5'(A_CTL + 1);
            localparam logic [4:0] A_LO = 5'(A_CTL + 2);
            localparam int P = c / 2;
            logic [7:0] nxt_ctl;
            logic [15:0] nxt_cmp;
            logic nxt_out;
            logic [1:0] fstep;
            logic [1:0] els;
            logic bufm, outm, capm, cap_ev, cmp_ev;
            logic [15:0] cmp_eff;

            // pair link: even channel owns, odd one idles
            if (c % 2 == 0) begin : g_even
                assign pair_on[P] = ctl_ff[c][B_BUF];
                assign dis[c] = 1'b0;
                assign cmp_eff = sel_ff[P] ? cmp_ff[c+1] : cmp_ff[c];
                assign bufm = ctl_ff[c][B_BUF];
                // pair switch happens only at wrap, avoiding a torn period
                always_ff @(posedge i_clk or posedge i_sys_rst) begin
                    if (i_sys_rst) begin
                        sel_ff[P] <= 1'b0;
                        last_ff[P] <= 1'b0;
                    end else begin
                        if (!pair_on[P]) begin
                            sel_ff[P] <= 1'b0;
                            last_ff[P] <= 1'b0;
                        end else begin
                            if (wr && (i_addr == A_HI || i_addr == A_LO)) begin
                                last_ff[P] <= 1'b0;
                            end else if (wr && (i_addr == 5'(A_HI + OFS_CH_STEP)
                                || i_addr == 5'(A_LO + OFS_CH_STEP))) begin
                                last_ff[P] <= 1'b1;
                            end
                            if (wrap_ev) begin
                                sel_ff[P] <= last_ff[P];
                            end
                        end
                    end
                end
            end else begin : g_odd
                assign dis[c] = pair_on[P];
                assign cmp_eff = cmp_ff[c];
                assign bufm = 1'b0;
            end

            // mode decode and next values
            always_comb begin
                els = ctl_ff[c][B_ELS+1:B_ELS];
                outm = !dis[c] && els != ELS_PORT && (bufm || ctl_ff[c][B_SINGLE]);
                capm = !dis[c] && els != ELS_PORT && !bufm && !ctl_ff[c][B_SINGLE];
                cap_ev = capm && ((els[0] && ch_s2_ff[c] && !ch_prev_ff[c])
                    || (els[1] && !ch_s2_ff[c] && ch_prev_ff[c]));
                cmp_ev = outm && adv && !clr_req && (nxt_cnt == cmp_eff);
                nxt_ctl = ctl_ff[c];
                if (wr && !dis[c] && i_addr == A_CTL) begin
                    nxt_ctl = i_wdata;
                    nxt_ctl[B_CH_FLAG] = 1'b0; // flag lives apart
                    if (c % 2 == 1) begin
                        nxt_ctl[B_BUF] = 1'b0; // odd channels have no pair bit
                    end
                end
                nxt_cmp = cmp_ff[c];
                if (cap_ev) begin // capture beats a coincident write
                    nxt_cmp = cnt_ff;
                end else if (wr && i_addr == A_HI) begin
                    nxt_cmp[15:8] = i_wdata;
                end else if (wr && i_addr == A_LO) begin
                    nxt_cmp[7:0] = i_wdata;
                end
                nxt_out = out_ff[c];
                if (els == ELS_PORT) begin // preset level, single mode 1 = low
                    nxt_out = !ctl_ff[c][B_SINGLE];
                end else if (outm) begin
                    if (ctl_ff[c][B_TOGGLE] && wrap_ev) begin
                        nxt_out = !out_ff[c];
                    end else if (cmp_ev) begin
                        case (els)
                            ELS_TOGGLE: nxt_out = !out_ff[c];
                            ELS_CLEAR: nxt_out = 1'b0;
                            ELS_SET: nxt_out = 1'b1;
                            default: nxt_out = out_ff[c];
                        endcase
                    end
                    if (ctl_ff[c][B_FULL] && !ctl_ff[c][B_TOGGLE]) begin
                        nxt_out = 1'b1;
                    end
                end
                fstep = flag_step(chf_ff[c], charm_ff[c], rd && !dis[c] && i_addr == A_CTL,
                    wr && !dis[c] && i_addr == A_CTL, i_wdata[B_CH_FLAG],
                    cap_ev || cmp_ev, allow);
            end

            // register channel state
            always_ff @(posedge i_clk or posedge i_sys_rst) begin
                if (i_sys_rst) begin
                    ctl_ff[c] <= RST_CTL;
                    cmp_ff[c] <= RST_CNT;
                    chf_ff[c] <= 1'b0;
                    charm_ff[c] <= 1'b0;
                    out_ff[c] <= RST_OUT;
                end else begin
                    ctl_ff[c] <= nxt_ctl;
                    cmp_ff[c] <= nxt_cmp;
                    chf_ff[c] <= fstep[1];
                    charm_ff[c] <= fstep[0];
                    out_ff[c] <= nxt_out;
                end
            end

            // pin: timer drives in compare modes, capture makes it an input, else port owns it
            assign o_chan_oe[c] = outm ? 1'b1 : (capm ? 1'b0 : i_port_chan_dir[c]);
            assign o_chan_out[c] = outm ? out_ff[c] : i_port_chan_out[c];
            assign ch_irq[c] = chf_ff[c] && ctl_ff[c][B_CH_IE] && !dis[c];
        end
    endgenerate

    // ==========================================
    // interrupt request, live in wait so it can wake the core
    assign o_irq = (wrap_flag_ff && wrap_ie_ff) || (|ch_irq);

    // ==========================================
    // read mux, clear bit always reads zero
    logic [7:0] rsel, nxt_rdata, rdata_ff;
    always_comb begin
        rsel = 8'h00;
        case (i_addr)
            OFS_STATUS: rsel = {wrap_flag_ff, wrap_ie_ff, halt_ff, 2'b00, div_ff};
            OFS_CNT_HI: rsel = cnt_ff[15:8];
            OFS_CNT_LO: rsel = cnt_ff[7:0];
            OFS_MOD_HI: rsel = mod_ff[15:8];
            OFS_MOD_LO: rsel = mod_ff[7:0];
            default: rsel = 8'h00;
        endcase
        for (int k = 0; k < TMR_NCH; k++) begin
            if (!dis[k] && i_addr == 5'(OFS_CH_BASE + k * OFS_CH_STEP)) begin
                rsel = ctl_ff[k];
                rsel[B_CH_FLAG] = chf_ff[k];
            end else if (i_addr == 5'(OFS_CH_BASE + k * OFS_CH_STEP + 1)) begin
                rsel = cmp_ff[k][15:8];
            end else if (i_addr == 5'(OFS_CH_BASE + k * OFS_CH_STEP + 2)) begin
                rsel = cmp_ff[k][7:0];
            end
        end
        nxt_rdata = rd ? rsel : 8'h00;
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end
    assign o_rdata = rdata_ff;
endmodule : tmr_four_channel

// ==== tmr_four_channel_checker.sv ====
// ==========================================
// watcher of the timer ports
module tmr_four_channel_checker
    import tmr_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [tmr_pkg::TMR_ADDR_W-1:0] i_addr,
    input wire logic [tmr_pkg::TMR_DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [tmr_pkg::TMR_DATA_W-1:0] o_rdata,
    input wire logic i_wait_mode,
    input wire logic i_port_d6_dir,
    input wire logic i_port_d6_out,
    input wire logic o_ext_clk_out,
    input wire logic o_ext_clk_oe,
    input wire logic [tmr_pkg::TMR_NCH-1:0] o_chan_out,
    input wire logic [tmr_pkg::TMR_NCH-1:0] o_chan_oe,
    input wire logic o_irq
);
    logic [7:0] ctl_ff [4]; // shadow of channel controls
    logic [2:0] div_ff; // shadow of divider select
    logic ie_ff; // shadow of wrap irq enable
    logic full0; // channel 0 held at full duty
    // ==========================================
    // shadows follow accepted writes only; strobes in wait are dropped
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            div_ff <= RST_DIV;
            ie_ff <= 1'b0;
            for (int c = 0; c < 4; c++) ctl_ff[c] <= RST_CTL;
        end else if (i_wr && !i_wait_mode) begin
            if (i_addr == OFS_STATUS) begin
                div_ff <= i_wdata[2:0];
                ie_ff <= i_wdata[B_WRAP_IE];
            end
            // odd channel writes vanish while its pair is linked
            for (int c = 0; c < 4; c++) begin
                if (i_addr == OFS_CH_BASE + 5'(3 * c) && !(c[0] && ctl_ff[c & 2][B_BUF]))
                    ctl_ff[c] <= i_wdata;
            end
        end
    end
    assign full0 = ctl_ff[0][B_FULL] && !ctl_ff[0][B_TOGGLE] && ctl_ff[0][B_SINGLE]
        && ctl_ff[0][3:2] != ELS_PORT;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // ==========================================
    // assertions
    chk_wait_read_zero: assert property ($past(i_rd) && $past(i_wait_mode) |-> o_rdata == 8'h00)
        else $error("read in wait returned data");
    chk_clear_bit_zero: assert property ($past(i_rd) && $past(i_addr) == OFS_STATUS
        |-> !o_rdata[B_CLEAR])
        else $error("clear bit read as one");
    chk_pair01_hides: assert property ($past(i_rd) && $past(i_addr) == 5'h08
        && $past(ctl_ff[0][B_BUF]) |-> o_rdata == 8'h00)
        else $error("linked channel 1 control visible");
    chk_pair23_hides: assert property ($past(i_rd) && $past(i_addr) == 5'h0E
        && $past(ctl_ff[2][B_BUF]) |-> o_rdata == 8'h00)
        else $error("linked channel 3 control visible");
    chk_ext_pin_input: assert property (div_ff == DIV_EXT |-> !o_ext_clk_oe)
        else $error("count clock pin driven");
    chk_ext_pin_port: assert property (div_ff != DIV_EXT |-> o_ext_clk_oe == i_port_d6_dir
        && o_ext_clk_out == i_port_d6_out)
        else $error("count clock pin not under port control");
    chk_capture_oe: assert property (ctl_ff[1][3:2] != ELS_PORT && !ctl_ff[1][B_SINGLE]
        && !ctl_ff[0][B_BUF] ##1 $stable(ctl_ff[1]) |-> !o_chan_oe[1])
        else $error("capture pin driven");
    chk_buf_overrides: assert property (ctl_ff[2][B_BUF] && ctl_ff[2][3:2] != ELS_PORT
        ##1 $stable(ctl_ff[2]) |-> o_chan_oe[2])
        else $error("buffered channel not driving");
    chk_full_duty: assert property (full0 [*3] |-> o_chan_out[0])
        else $error("full duty output low");
    chk_irq_quiet: assert property (!(ie_ff || ctl_ff[0][B_CH_IE] || ctl_ff[1][B_CH_IE]
        || ctl_ff[2][B_CH_IE] || ctl_ff[3][B_CH_IE]) |-> !o_irq)
        else $error("irq with all enables clear");
endmodule : tmr_four_channel_checker

// ==== tmr_pin_model.sv ====
// ==========================================
// pins outside the timer
module tmr_pin_model (
    input wire logic i_clk,
    input wire logic i_run_ext,
    input wire logic [3:0] i_lvl,
    input wire logic i_ext_out,
    input wire logic i_ext_oe,
    input wire logic [3:0] i_chan_out,
    input wire logic [3:0] i_chan_oe,
    output logic o_ext_pin,
    output logic [3:0] o_chan_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] ph = 3'h0; // phase of the count clock
    // four bus clocks low then high, well under half the bus rate
    always @(posedge i_clk) ph <= i_run_ext ? ph + 3'h1 : 3'h0;
    // the clock stands low outside bursts; a driving port wins the wire
    assign o_ext_pin = i_ext_oe ? i_ext_out : (i_run_ext && ph[2]);
    assign o_chan_pin = (i_chan_oe & i_chan_out) | (~i_chan_oe & i_lvl);
endmodule : tmr_pin_model

// ==== tmr_four_channel_test.sv ====
// ==========================================
// self-checking bench
module tmr_four_channel_test;
    timeunit 1ns;
    timeprecision 1ns;
    import tmr_pkg::*;
    logic i_clk = 0, i_sys_rst = 1, i_wr = 0, i_rd = 0, i_wait_mode = 0;
    logic i_break_active = 0, i_break_flag_clear_enable = 0, i_port_d6_dir = 0;
    logic i_port_d6_out = 0, run_ext = 0, o_ext_clk_out, o_ext_clk_oe, o_irq, ext_pin;
    logic [4:0] i_addr = 0;
    logic [7:0] i_wdata = 0, o_rdata, d;
    logic [3:0] i_port_chan_dir = 0, i_port_chan_out = 0, lvl = 0;
    logic [3:0] o_chan_out, o_chan_oe, chan_pin;
    logic [15:0] a, b;
    integer seed = 32'hde49, n_fail = 0, cmp_count = 0, tick = 0;
    initial forever #50 i_clk = ~i_clk;
    tmr_four_channel dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_wait_mode(i_wait_mode), .i_break_active(i_break_active),
        .i_break_flag_clear_enable(i_break_flag_clear_enable), .i_ext_clk_pin(ext_pin),
        .i_port_d6_dir(i_port_d6_dir), .i_port_d6_out(i_port_d6_out),
        .o_ext_clk_out(o_ext_clk_out), .o_ext_clk_oe(o_ext_clk_oe), .i_chan_pin(chan_pin),
        .i_port_chan_dir(i_port_chan_dir), .i_port_chan_out(i_port_chan_out),
        .o_chan_out(o_chan_out), .o_chan_oe(o_chan_oe), .o_irq(o_irq));
    tmr_pin_model u_pins (.i_clk(i_clk), .i_run_ext(run_ext), .i_lvl(lvl),
        .i_ext_out(o_ext_clk_out), .i_ext_oe(o_ext_clk_oe), .i_chan_out(o_chan_out),
        .i_chan_oe(o_chan_oe), .o_ext_pin(ext_pin), .o_chan_pin(chan_pin));
    // random port latches keep the shared pins busy all run long
    always @(posedge i_clk) begin
        {i_port_d6_dir, i_port_d6_out, i_port_chan_dir, i_port_chan_out} <= 10'($random(seed));
        tick <= tick + 1;
        if (tick == 20000) begin
            n_fail = n_fail + 1;
            report_and_stop();
        end
    end
    // ==========================================
    // bus tasks and comparison
    task automatic wr(input logic [4:0] ad, input logic [7:0] wd);
        @(posedge i_clk);
        {i_addr, i_wdata, i_wr} <= {ad, wd, 1'b1};
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] ad);
        @(posedge i_clk);
        {i_addr, i_rd} <= {ad, 1'b1};
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata; // data stands in this cycle only
    endtask : rd
    task automatic rd16(input logic [4:0] ad, output logic [15:0] v);
        rd(ad);
        v[15:8] = d;
        rd(ad + 5'h01);
        v[7:0] = d;
    endtask : rd16
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // expected tick count after n bus clocks at divider k
    function automatic logic in_win(input logic [15:0] c, input int k);
        return c >= 16'(126 >> k) && c <= 16'((134 >> k) + 1);
    endfunction : in_win
    task automatic report_and_stop();
        if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : report_and_stop
    // ==========================================
    // main sequence
    initial begin
        repeat (6) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rd(OFS_STATUS); chk(d, 16'h0020);
        repeat (20) @(posedge i_clk);
        rd16(OFS_CNT_HI, a); chk(a, RST_CNT);
        rd16(OFS_MOD_HI, a); chk(a, RST_MOD);
        for (int k = 0; k < 7; k++) begin
            wr(OFS_STATUS, 8'(8'h30 + k));
            rd16(OFS_CNT_HI, a); chk(a, 16'h0000);
            wr(OFS_STATUS, 8'(k));
            repeat (128) @(posedge i_clk);
            wr(OFS_STATUS, 8'(8'h20 + k));
            rd16(OFS_CNT_HI, a); chk(in_win(a, k), 1);
        end
        wr(OFS_STATUS, 8'h37);
        wr(OFS_STATUS, 8'h07);
        run_ext <= 1'b1;
        repeat (80) @(posedge i_clk);
        run_ext <= 1'b0;
        repeat (8) @(posedge i_clk);
        wr(OFS_STATUS, 8'h27);
        rd16(OFS_CNT_HI, a); chk(a, 16'd10);
        wr(OFS_STATUS, 8'h00);
        rd16(OFS_CNT_HI, a);
        @(posedge i_clk) i_wait_mode <= 1'b1;
        rd(OFS_STATUS); chk(d, 16'h0000);
        wr(OFS_STATUS, 8'h20);
        repeat (20) @(posedge i_clk);
        i_wait_mode <= 1'b0;
        rd16(OFS_CNT_HI, b); chk(b - a > 16'd20, 1);
        wr(OFS_STATUS, 8'h30);
        wr(OFS_MOD_HI, 8'h00);
        wr(OFS_MOD_LO, 8'h03);
        wr(OFS_STATUS, 8'h00);
        repeat (12) @(posedge i_clk);
        wr(OFS_STATUS, 8'h20);
        rd(OFS_STATUS); chk(d, 16'h00A0);
        chk(o_irq, 0);
        wr(OFS_STATUS, 8'hE0);
        #1 chk(o_irq, 1);
        rd(OFS_STATUS);
        wr(OFS_STATUS, 8'h20);
        rd(OFS_STATUS); chk(d, 16'h0020);
        chk(o_irq, 0);
        wr(OFS_STATUS, 8'h00);
        repeat (8) @(posedge i_clk);
        rd(OFS_STATUS);
        repeat (8) @(posedge i_clk);
        wr(OFS_STATUS, 8'h20);
        rd(OFS_STATUS); chk(d, 16'h00A0);
        @(posedge i_clk) i_break_active <= 1'b1;
        wr(OFS_STATUS, 8'h20);
        rd(OFS_STATUS); chk(d, 16'h00A0);
        @(posedge i_clk) i_break_active <= 1'b0;
        wr(OFS_STATUS, 8'h20);
        rd(OFS_STATUS); chk(d, 16'h0020);
        wr(OFS_STATUS, 8'h00);
        repeat (9) @(posedge i_clk);
        {i_break_active, i_break_flag_clear_enable} <= 2'b11;
        rd16(OFS_CNT_HI, a);
        repeat (10) @(posedge i_clk);
        rd16(OFS_CNT_HI, b); chk(b, a);
        rd(OFS_STATUS);
        wr(OFS_STATUS, 8'h20);
        {i_break_active, i_break_flag_clear_enable} <= 2'b00;
        rd(OFS_STATUS); chk(d, 16'h0020);
        wr(OFS_STATUS, 8'h00);
        wr(5'h05, 8'h10);
        wr(5'h06, 8'h00);
        wr(5'h07, 8'h01);
        wr(5'h05, 8'h18);
        repeat (8) begin
            @(posedge i_clk);
            #1 chk(o_chan_out[0], 0);
        end
        rd(5'h05); chk(d[7], 1);
        wr(5'h05, 8'h19);
        repeat (3) @(posedge i_clk);
        #1 chk(o_chan_out[0], 1);
        wr(5'h05, 8'h38);
        wr(5'h08, 8'h5C);
        rd(5'h08); chk(d, 16'h0000);
        wr(5'h05, 8'h00);
        wr(5'h0B, 8'h28);
        repeat (2) @(posedge i_clk);
        #1 chk(o_chan_oe[2], 1);
        rd(5'h0E); chk(d, 16'h0000);
        wr(5'h0B, 8'h00);
        wr(5'h08, 8'h44);
        repeat (4) @(posedge i_clk);
        // drop a capture left over from the random port level
        rd(5'h08);
        wr(5'h08, 8'h44);
        lvl[1] <= 1'b1;
        repeat (6) @(posedge i_clk);
        rd(5'h08); chk(d[7], 1);
        chk(o_irq, 1);
        wr(5'h08, 8'h44);
        #1 chk(o_irq, 0);
        wr(5'h0F, 8'h00);
        wr(5'h10, 8'h01);
        for (int e = 1; e < 4; e++) begin
            wr(5'h0E, 8'(8'h10 + 4 * e));
            repeat (8) @(posedge i_clk);
            #1 a[0] = o_chan_out[3];
            repeat (4) @(posedge i_clk);
            #1 b[0] = o_chan_out[3];
            chk(e == 1 ? a[0] != b[0] : a[0] == e[0] && b[0] == e[0], 1);
        end
        // compare at zero meets every wrap: the wrap toggle must win over clear
        wr(5'h10, 8'h00);
        wr(5'h0E, 8'h1A);
        repeat (8) @(posedge i_clk);
        #1 a[0] = o_chan_out[3];
        repeat (4) @(posedge i_clk);
        #1 b[0] = o_chan_out[3];
        chk(a[0] != b[0], 1);
        report_and_stop();
    end
endmodule : tmr_four_channel_test
bind tmr_four_channel tmr_four_channel_checker u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_wait_mode(i_wait_mode), .i_port_d6_dir(i_port_d6_dir), .i_port_d6_out(i_port_d6_out),
    .o_ext_clk_out(o_ext_clk_out), .o_ext_clk_oe(o_ext_clk_oe), .o_chan_out(o_chan_out),
    .o_chan_oe(o_chan_oe), .o_irq(o_irq));
